// >>> design/cict_decode.v
/*
 Combinational clock-figure decoder: class code and operand state in,
 issue, repeat and latency figures out.
 Assumes wait-state counts come from the memory interface on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cict_defines.vh"
module cict_decode (
   // instruction
   input  wire [`CICT_CLS_W-1:0]  cls,
   input  wire [`CICT_LIST_W-1:0] reg_list,
   // environment
   input  wire                    type_b,
   input  wire [`CICT_WAIT_W-1:0] read_waits,
   input  wire [`CICT_WAIT_W-1:0] list_waits,
   // figures
   output reg  [`CICT_CNT_W-1:0]  fig_issue,
   output reg  [`CICT_CNT_W-1:0]  fig_repeat,
   output reg  [`CICT_CNT_W-1:0]  fig_latency,
   output reg                     illegal
);
   // n: listed registers, each stretched by its wait states, never below one
   function [`CICT_CNT_W-1:0] cict_list_cycles;
      input [`CICT_LIST_W-1:0] lst;
      input [`CICT_WAIT_W-1:0] wt;
      integer k;
      reg [`CICT_CNT_W-1:0] cnt;
      begin
         cnt = {`CICT_CNT_W{1'b0}};
         for (k = 0; k < `CICT_LIST_W; k = k + 1) begin
            cnt = cnt + {{(`CICT_CNT_W-1){1'b0}}, lst[k]};
         end
         cnt = cnt * ({{(`CICT_CNT_W-`CICT_WAIT_W){1'b0}}, wt} + `CICT_CLK_ONE);
         cict_list_cycles = (cnt < `CICT_N_MIN) ? `CICT_N_MIN : cnt;
      end
   endfunction

   reg [`CICT_CNT_W-1:0] base;
   reg [`CICT_CNT_W-1:0] n;
   reg                   noted;

   always @* begin
      n       = cict_list_cycles(reg_list, list_waits);
      base    = `CICT_CLK_THREE;
      noted   = 1'b0;
      illegal = 1'b0;
      case (cls)
         `CICT_CLS_JUMP_LINK, `CICT_CLS_REL_JUMP: begin
            base  = `CICT_CLK_TWO;
            noted = 1'b1;
         end
         `CICT_CLS_REG_JUMP: begin
            base  = `CICT_CLK_THREE;
            noted = 1'b1;
         end
         `CICT_CLS_BIT_CLEAR, `CICT_CLS_BIT_INVERT, `CICT_CLS_BIT_SET, `CICT_CLS_BIT_TEST:
            base = `CICT_CLK_THREE + {{(`CICT_CNT_W-`CICT_WAIT_W){1'b0}}, read_waits};
         `CICT_CLS_TABLE_CALL: begin
            base  = `CICT_CLK_FOUR;
            noted = 1'b1;
         end
         `CICT_CLS_TABLE_RET: begin
            base  = `CICT_CLK_THREE;
            noted = 1'b1;
         end
         `CICT_CLS_INT_DISABLE, `CICT_CLS_INT_ENABLE, `CICT_CLS_HALT, `CICT_CLS_NOP,
         `CICT_CLS_SYSREG_LOAD, `CICT_CLS_SYSREG_STORE:
            base = `CICT_CLK_ONE;
         `CICT_CLS_TABLE_BRANCH:
            base = `CICT_CLK_FIVE;
         `CICT_CLS_INT_RETURN, `CICT_CLS_TRAP: begin
            base  = `CICT_CLK_THREE;
            noted = 1'b1;
         end
         `CICT_CLS_DEBUG_RET, `CICT_CLS_DEBUG_TRAP: begin
            base  = `CICT_CLK_THREE;
            noted = 1'b1;
         end
         `CICT_CLS_REL_PLAIN:    base = n + `CICT_CLK_ONE;
         `CICT_CLS_REL_JUMP_REG: base = n + `CICT_CLK_THREE;
         `CICT_CLS_SETUP_PLAIN:  base = n + `CICT_CLK_ONE;
         `CICT_CLS_SETUP_SP, `CICT_CLS_SETUP_IMM16:
            base = n + `CICT_CLK_TWO;
         `CICT_CLS_SETUP_IMM32:  base = n + `CICT_CLK_THREE;
         default: begin
            base    = `CICT_CLK_THREE;
            illegal = 1'b1;
         end
      endcase
      if (noted && type_b) begin
         base = base + `CICT_VARIANT_EXTRA;
      end
      // the three figures coincide for every class handled here
      fig_issue   = base;
      fig_repeat  = base;
      fig_latency = base;
   end
endmodule // cict_decode
`default_nettype wire

// >>> design/cict_defines.vh
/*
 Shared constants of the instruction cycle timing block: class codes,
 instruction field positions, clock figures and widths.
 Assumes the fetch decoder delivers one class code per issued instruction.
*/
//
// Behaviour
// - register-indirect jump takes three clocks
// - bit ops: three clocks plus read waits
// - table_call four, table_call_return three clocks
// - di, ei, halt, nop, sysreg ops: one
// - table branch by register takes five clocks
// - undefined code takes three, then illegal trap
// - type B variant adds one to noted ops
// - frame_release n+1, with jump n+3
// - frame_setup n+1, sp/imm16 n+2, imm32 n+3
// - n is list count, grows with waits, min one
// - trap carries a five-bit vector field
// - bit number three bits, condition four bits
// - third operand gets remainder or product high
// - issue, repeat, latency figures by follower relation
`ifndef CICT_DEFINES_VH
`define CICT_DEFINES_VH

`define CICT_CLS_W            5
`define CICT_CLS_JUMP_LINK    5'h00
`define CICT_CLS_REL_JUMP     5'h01
`define CICT_CLS_REG_JUMP     5'h02
`define CICT_CLS_BIT_CLEAR    5'h03
`define CICT_CLS_BIT_INVERT   5'h04
`define CICT_CLS_BIT_SET      5'h05
`define CICT_CLS_BIT_TEST     5'h06
`define CICT_CLS_TABLE_CALL   5'h07
`define CICT_CLS_TABLE_RET    5'h08
`define CICT_CLS_INT_DISABLE  5'h09
`define CICT_CLS_INT_ENABLE   5'h0A
`define CICT_CLS_HALT         5'h0B
`define CICT_CLS_NOP          5'h0C
`define CICT_CLS_SYSREG_LOAD  5'h0D
`define CICT_CLS_SYSREG_STORE 5'h0E
`define CICT_CLS_TABLE_BRANCH 5'h0F
`define CICT_CLS_INT_RETURN   5'h10
`define CICT_CLS_TRAP         5'h11
`define CICT_CLS_DEBUG_RET    5'h12
`define CICT_CLS_DEBUG_TRAP   5'h13
`define CICT_CLS_REL_PLAIN    5'h14
`define CICT_CLS_REL_JUMP_REG 5'h15
`define CICT_CLS_SETUP_PLAIN  5'h16
`define CICT_CLS_SETUP_SP     5'h17
`define CICT_CLS_SETUP_IMM16  5'h18
`define CICT_CLS_SETUP_IMM32  5'h19

`define CICT_CNT_W            8
`define CICT_CNT_MAX          8'hFF
`define CICT_CLK_ONE          8'h01
`define CICT_CLK_TWO          8'h02
`define CICT_CLK_THREE        8'h03
`define CICT_CLK_FOUR         8'h04
`define CICT_CLK_FIVE         8'h05
`define CICT_VARIANT_EXTRA    8'h01
`define CICT_N_MIN            8'h01

`define CICT_WAIT_W           4
`define CICT_LIST_W           12
`define CICT_LIST_LSB         20
`define CICT_LIST_MSB         31
`define CICT_VEC_W            5
`define CICT_VEC_LSB          0
`define CICT_VEC_MSB          4
`define CICT_BIT_W            3
`define CICT_BIT_LSB          11
`define CICT_BIT_MSB          13
`define CICT_CC_W             4
`define CICT_CC_LSB           0
`define CICT_CC_MSB           3
`define CICT_WORD_W           32

`endif

// >>> design/cict_stall.v
/*
 Issue stall counter: counts clocks since the last accepted instruction
 and raises one readiness flag per follower relation.
 Assumes load is only asserted when the matching readiness flag was high.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cict_defines.vh"
module cict_stall (
   // clock and reset
   input  wire                   clk,
   input  wire                   rst_n,
   // load
   input  wire                   load,
   input  wire [`CICT_CNT_W-1:0] load_issue,
   input  wire [`CICT_CNT_W-1:0] load_repeat,
   input  wire [`CICT_CNT_W-1:0] load_latency,
   // status
   output reg                    ready_other,
   output reg                    ready_repeat,
   output reg                    ready_dependent,
   output reg                    last,
   output reg                    busy
);
   reg [`CICT_CNT_W-1:0] elapsed;
   reg [`CICT_CNT_W-1:0] fig_i;
   reg [`CICT_CNT_W-1:0] fig_r;
   reg [`CICT_CNT_W-1:0] fig_l;
   reg [`CICT_CNT_W-1:0] next_elapsed;
   reg [`CICT_CNT_W-1:0] next_fig_i;
   reg [`CICT_CNT_W-1:0] next_fig_r;
   reg [`CICT_CNT_W-1:0] next_fig_l;

   always @* begin
      next_fig_i   = load ? load_issue   : fig_i;
      next_fig_r   = load ? load_repeat  : fig_r;
      next_fig_l   = load ? load_latency : fig_l;
      // saturate so an idle pipe stays ready forever
      if (load) begin
         next_elapsed = `CICT_CLK_ONE;
      end else if (elapsed == `CICT_CNT_MAX) begin
         next_elapsed = elapsed;
      end else begin
         next_elapsed = elapsed + `CICT_CLK_ONE;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         elapsed         <= `CICT_CNT_MAX;
         fig_i           <= `CICT_CLK_ONE;
         fig_r           <= `CICT_CLK_ONE;
         fig_l           <= `CICT_CLK_ONE;
         ready_other     <= 1'b1;
         ready_repeat    <= 1'b1;
         ready_dependent <= 1'b1;
         last            <= 1'b0;
         busy            <= 1'b0;
      end else begin
         elapsed         <= next_elapsed;
         fig_i           <= next_fig_i;
         fig_r           <= next_fig_r;
         fig_l           <= next_fig_l;
         ready_other     <= (next_elapsed >= next_fig_i);
         ready_repeat    <= (next_elapsed >= next_fig_r);
         ready_dependent <= (next_elapsed >= next_fig_l);
         last            <= (next_elapsed == next_fig_i);
         busy            <= (next_elapsed <  next_fig_i);
      end
   end
endmodule // cict_stall
`default_nettype wire

// >>> design/cict_top.v
/*
 Top of the instruction cycle timing block: accepts classified instructions,
 holds issue until their clock figure has passed, extracts operand fields
 and routes the third-operand result.
 Assumes the fetch stage holds a request until it is taken and the variant
 strap is a static pin level.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cict_defines.vh"
module cict_top (
   // clock and reset
   input  wire                    clk,
   input  wire                    rst_n,
   // variant strap pin
   input  wire                    type_b_pin,
   // instruction request
   input  wire                    req_valid,
   input  wire [`CICT_CLS_W-1:0]  req_class,
   input  wire [`CICT_WORD_W-1:0] req_word,
   input  wire                    req_uses_result,
   // memory wait states
   input  wire [`CICT_WAIT_W-1:0] read_waits,
   input  wire [`CICT_WAIT_W-1:0] list_waits,
   // multiply and divide results
   input  wire                    res_valid,
   input  wire                    res_is_div,
   input  wire [`CICT_WORD_W-1:0] div_remainder,
   input  wire [`CICT_WORD_W-1:0] product_high,
   // issue status
   output reg                     ready_other,
   output reg                     ready_repeat,
   output reg                     ready_dependent,
   output reg                     issue_ack,
   output reg                     busy,
   output reg                     instr_done,
   output reg                     illegal_trap,
   output reg  [`CICT_CNT_W-1:0]  cur_clocks,
   // operand fields
   output reg  [`CICT_VEC_W-1:0]  trap_vector,
   output reg                     trap_valid,
   output reg  [`CICT_BIT_W-1:0]  bit_number,
   output reg  [`CICT_CC_W-1:0]   cond_code,
   // third operand write
   output reg                     reg3_we,
   output reg  [`CICT_WORD_W-1:0] reg3_data
);
   reg                    type_b_meta;
   reg                    type_b_sync;
   reg [`CICT_CLS_W-1:0]  last_class;
   reg                    last_valid;
   reg                    cur_illegal;
   reg                    cur_trap;
   reg                    next_take;
   reg                    next_same;

   wire [`CICT_CNT_W-1:0] fig_issue;
   wire [`CICT_CNT_W-1:0] fig_repeat;
   wire [`CICT_CNT_W-1:0] fig_latency;
   wire                   dec_illegal;
   wire                   st_ready_other;
   wire                   st_ready_repeat;
   wire                   st_ready_dependent;
   wire                   st_last;
   wire                   st_busy;

   // strap crosses in from a pin, so two flops before use
   always @(posedge clk) begin
      if (!rst_n) begin
         type_b_meta <= 1'b0;
         type_b_sync <= 1'b0;
      end else begin
         type_b_meta <= type_b_pin;
         type_b_sync <= type_b_meta;
      end
   end

   cict_decode u_decode (
      .cls         (req_class),
      .reg_list    (req_word[`CICT_LIST_MSB:`CICT_LIST_LSB]),
      .type_b      (type_b_sync),
      .read_waits  (read_waits),
      .list_waits  (list_waits),
      .fig_issue   (fig_issue),
      .fig_repeat  (fig_repeat),
      .fig_latency (fig_latency),
      .illegal     (dec_illegal)
   );

   // follower relation picks which figure gates acceptance
   always @* begin
      next_same = last_valid && (req_class == last_class);
      if (!req_valid) begin
         next_take = 1'b0;
      end else if (req_uses_result) begin
         next_take = st_ready_dependent;
      end else if (next_same) begin
         next_take = st_ready_repeat;
      end else begin
         next_take = st_ready_other;
      end
   end

   cict_stall u_stall (
      .clk             (clk),
      .rst_n           (rst_n),
      .load            (next_take),
      .load_issue      (fig_issue),
      .load_repeat     (fig_repeat),
      .load_latency    (fig_latency),
      .ready_other     (st_ready_other),
      .ready_repeat    (st_ready_repeat),
      .ready_dependent (st_ready_dependent),
      .last            (st_last),
      .busy            (st_busy)
   );

   // issue bookkeeping and operand field capture
   always @(posedge clk) begin
      if (!rst_n) begin
         last_class  <= `CICT_CLS_NOP;
         last_valid  <= 1'b0;
         cur_illegal <= 1'b0;
         cur_trap    <= 1'b0;
         issue_ack   <= 1'b0;
         cur_clocks  <= `CICT_CLK_ONE;
         trap_vector <= {`CICT_VEC_W{1'b0}};
         bit_number  <= {`CICT_BIT_W{1'b0}};
         cond_code   <= {`CICT_CC_W{1'b0}};
      end else begin
         issue_ack <= next_take;
         if (next_take) begin
            last_class  <= req_class;
            last_valid  <= 1'b1;
            cur_illegal <= dec_illegal;
            cur_trap    <= (req_class == `CICT_CLS_TRAP);
            cur_clocks  <= fig_issue;
            trap_vector <= req_word[`CICT_VEC_MSB:`CICT_VEC_LSB];
            bit_number  <= req_word[`CICT_BIT_MSB:`CICT_BIT_LSB];
            cond_code   <= req_word[`CICT_CC_MSB:`CICT_CC_LSB];
         end
      end
   end

   // stall status mirrored onto flops; completion pulses follow the count
   always @(posedge clk) begin
      if (!rst_n) begin
         ready_other     <= 1'b1;
         ready_repeat    <= 1'b1;
         ready_dependent <= 1'b1;
         busy            <= 1'b0;
         instr_done      <= 1'b0;
         illegal_trap    <= 1'b0;
         trap_valid      <= 1'b0;
      end else begin
         ready_other     <= st_ready_other;
         ready_repeat    <= st_ready_repeat;
         ready_dependent <= st_ready_dependent;
         busy            <= st_busy;
         instr_done      <= st_last;
         // handler entry only after the full figure has run: three clocks, four for a type B trap
         illegal_trap    <= st_last && cur_illegal;
         trap_valid      <= st_last && cur_trap;
      end
   end

   // third operand takes remainder or upper product half
   always @(posedge clk) begin
      if (!rst_n) begin
         reg3_we   <= 1'b0;
         reg3_data <= {`CICT_WORD_W{1'b0}};
      end else begin
         reg3_we <= res_valid;
         if (res_valid) begin
            reg3_data <= res_is_div ? div_remainder : product_high;
         end
      end
   end
endmodule // cict_top
`default_nettype wire

// >>> dv/cict_mem_model.sv
/*
 Memory bus wait-state model for the cycle timing block: answers promptly or slowly.
 Assumes slow is a level from the bench, changed only while the core is idle.
*/
`timescale 1ns/1ps
`default_nettype none
module cict_mem_model #(
   parameter logic [3:0] RD_W = 4'h2,
   parameter logic [3:0] LS_W = 4'h1
) (
   // clock
   input  wire logic       clk,
   // mode
   input  wire logic       slow,
   // waits to the core
   output var  logic [3:0] read_waits,
   output var  logic [3:0] list_waits
);
   // registered, so waits never move between two edges
   always @(posedge clk) begin
      read_waits <= slow ? RD_W : 4'h0;
      list_waits <= slow ? LS_W : 4'h0;
   end
endmodule // cict_mem_model
`default_nettype wire

// >>> dv/cict_top_asserts.sv
/*
 Port timing checker of cict_top, bound to it.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cict_defines.vh"
module cict_top_asserts (
   // clock and reset
   input wire logic                    clk,
   input wire logic                    rst_n,
   // inputs
   input wire logic [`CICT_CLS_W-1:0]  req_class,
   input wire logic [`CICT_WORD_W-1:0] req_word,
   input wire logic [`CICT_WAIT_W-1:0] read_waits,
   input wire logic                    res_valid,
   input wire logic                    res_is_div,
   input wire logic [`CICT_WORD_W-1:0] div_remainder,
   input wire logic [`CICT_WORD_W-1:0] product_high,
   // outputs
   input wire logic                    issue_ack,
   input wire logic                    instr_done,
   input wire logic                    busy,
   input wire logic                    ready_other,
   input wire logic                    ready_repeat,
   input wire logic                    ready_dependent,
   input wire logic                    trap_valid,
   input wire logic                    illegal_trap,
   input wire logic [`CICT_CNT_W-1:0]  cur_clocks,
   input wire logic [`CICT_VEC_W-1:0]  trap_vector,
   input wire logic [`CICT_BIT_W-1:0]  bit_number,
   input wire logic [`CICT_CC_W-1:0]   cond_code,
   input wire logic                    reg3_we,
   input wire logic [`CICT_WORD_W-1:0] reg3_data
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [7:0] gap;
   logic [7:0] prev_fig;
   // saturating, so a long idle never wraps into a false early take
   always @(posedge clk) begin
      if (!rst_n) begin
         gap      <= 8'hFF;
         prev_fig <= 8'h01;
      end else if (issue_ack) begin
         gap      <= 8'h01;
         prev_fig <= cur_clocks;
      end else if (gap != 8'hFF) begin
         gap <= gap + 8'h01;
      end
   end
   issue_spacing_a: assert property (issue_ack |-> gap >= prev_fig)
      else $error("take came before the figure elapsed");
   reg3_route_a: assert property (res_valid |=> reg3_we &&
      reg3_data == ($past(res_is_div) ? $past(div_remainder) : $past(product_high)))
      else $error("third operand write wrong");
   reg3_quiet_a: assert property (!res_valid |=> !reg3_we)
      else $error("third operand write without result");
   single_clock_a: assert property (issue_ack && $past(req_class) == 5'h0C |-> cur_clocks == 8'h01)
      else $error("no-operation figure wrong");
   table_branch_a: assert property (issue_ack && $past(req_class) == 5'h0F |-> cur_clocks == 8'h05)
      else $error("table branch figure wrong");
   bit_waits_a: assert property (issue_ack && $past(req_class) inside {[5'h03:5'h06]}
      |-> cur_clocks == 8'h03 + $past(read_waits))
      else $error("bit op figure wrong");
   undef_trap_a: assert property (issue_ack && $past(req_class) >= 5'h1A |-> ##3 (instr_done && illegal_trap))
      else $error("undefined code not trapped after three clocks");
   // status outputs lag the stall counter by one flop, hence the next-cycle check
   stall_flags_a: assert property (issue_ack && cur_clocks > 8'h01 |=>
      busy && !ready_other && !ready_repeat && !ready_dependent)
      else $error("stall status not raised after a multi-clock take");
   trap_done_a: assert property (issue_ack && $past(req_class) == 5'h11 && cur_clocks == 8'h03
      |-> ##3 (instr_done && trap_valid))
      else $error("trap completion pulse missing after three clocks");
   trap_field_a: assert property (issue_ack && $past(req_class) == 5'h11 |-> trap_vector == $past(req_word[4:0]))
      else $error("trap vector field wrong");
   op_fields_a: assert property (issue_ack |-> bit_number == $past(req_word[13:11]) &&
      cond_code == $past(req_word[3:0]))
      else $error("bit number or condition field wrong");
   cover property (issue_ack && cur_clocks == 8'h05);
   cover property (reg3_we);
   cover property (illegal_trap);
endmodule // cict_top_asserts
bind cict_top cict_top_asserts cict_top_asserts_i (.clk(clk), .rst_n(rst_n), .req_class(req_class),
   .req_word(req_word), .read_waits(read_waits), .res_valid(res_valid), .res_is_div(res_is_div),
   .div_remainder(div_remainder), .product_high(product_high), .issue_ack(issue_ack), .instr_done(instr_done),
   .busy(busy), .ready_other(ready_other), .ready_repeat(ready_repeat), .ready_dependent(ready_dependent),
   .trap_valid(trap_valid),
   .illegal_trap(illegal_trap), .cur_clocks(cur_clocks), .trap_vector(trap_vector), .bit_number(bit_number),
   .cond_code(cond_code), .reg3_we(reg3_we), .reg3_data(reg3_data));
`default_nettype wire

// >>> dv/cict_top_bench.sv
/*
 Self-checking bench of cict_top with the memory wait-state model.
 Assumes the checker is bound to cict_top.
*/
`timescale 1ns/1ps
`default_nettype none
module cict_top_bench;
   localparam logic [3:0] RD = 4'h2;
   localparam logic [3:0] LW = 4'h1;
   // three listed registers while slow
   localparam logic [7:0] NS = 8'h03 * (8'h01 + {4'h0, LW});
   logic        clk;
   logic        rst_n = 1'b0, type_b_pin = 1'b0, req_valid = 1'b0, req_uses_result = 1'b0, slow = 1'b0;
   logic        res_valid = 1'b0, res_is_div = 1'b0;
   logic [4:0]  req_class = 5'h00;
   logic [31:0] req_word = 32'h0, div_remainder = 32'h0, product_high = 32'h0;
   logic [3:0]  read_waits, list_waits;
   logic        ready_other, ready_repeat, ready_dependent, issue_ack, busy, reg3_we;
   logic [7:0]  cur_clocks;
   logic [4:0]  trap_vector;
   logic [2:0]  bit_number;
   logic [3:0]  cond_code;
   logic [31:0] reg3_data;
   int          bad_count = 0;
   int          total_checks = 0;
   cict_mem_model #(.RD_W(RD), .LS_W(LW)) cict_mem_model_i (.clk(clk), .slow(slow), .read_waits(read_waits),
      .list_waits(list_waits));
   cict_top cict_top_i (.clk(clk), .rst_n(rst_n), .type_b_pin(type_b_pin), .req_valid(req_valid),
      .req_class(req_class), .req_word(req_word), .req_uses_result(req_uses_result), .read_waits(read_waits),
      .list_waits(list_waits), .res_valid(res_valid), .res_is_div(res_is_div), .div_remainder(div_remainder),
      .product_high(product_high), .ready_other(ready_other), .ready_repeat(ready_repeat),
      .ready_dependent(ready_dependent),
      .issue_ack(issue_ack), .busy(busy), .instr_done(), .illegal_trap(), .cur_clocks(cur_clocks),
      .trap_vector(trap_vector), .trap_valid(), .bit_number(bit_number), .cond_code(cond_code),
      .reg3_we(reg3_we), .reg3_data(reg3_data));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] base(input logic [4:0] c);
      case (c)
         5'h00, 5'h01: return 8'h02;
         5'h07: return 8'h04;
         5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E: return 8'h01;
         5'h0F: return 8'h05;
         default: return 8'h03;
      endcase
   endfunction
   function automatic logic [7:0] extra(input logic [4:0] c);
      return (c < 5'h03 || c == 5'h07 || c == 5'h08 || (c > 5'h0F && c < 5'h14)) ? 8'h01 : 8'h00;
   endfunction
   // request held over two takes of one class; the ack spacing is the figure
   task automatic pair(input logic [4:0] c, input logic [31:0] w, input logic u, input logic [7:0] exp);
      int k;
      int first;
      int second;
      first = -1;
      second = -1;
      @(posedge clk);
      req_valid <= 1'b1;
      req_class <= c;
      req_word <= w;
      req_uses_result <= u;
      for (k = 0; k < 300 && second < 0; k++) begin
         @(posedge clk);
         if (issue_ack === 1'b1 && first >= 0) second = k;
         if (issue_ack === 1'b1 && first < 0) first = k;
      end
      req_valid <= 1'b0;
      chk(32'(second - first), 32'(exp));
      chk(32'(cur_clocks), 32'(exp));
      repeat (3) @(posedge clk);
      for (k = 0; k < 300 && busy !== 1'b0; k++) @(posedge clk);
      repeat (2) @(posedge clk);
      chk(32'({busy, ready_other, ready_repeat, ready_dependent}), 32'h7);
   endtask
   task automatic t_basic;
      logic [4:0] c;
      for (c = 5'h00; c < 5'h14; c++) pair(c, 32'h0, 1'b0, base(c));
      pair(5'h1A, 32'h0, 1'b0, 8'h03);
      pair(5'h1F, 32'h0, 1'b0, 8'h03);
      pair(5'h0F, 32'h0, 1'b1, 8'h05);
      $display("t_basic done");
   endtask
   task automatic t_variant;
      logic [4:0] c;
      type_b_pin <= 1'b1;
      // strap passes a two-flop synchroniser
      repeat (4) @(posedge clk);
      for (c = 5'h00; c < 5'h14; c++) pair(c, 32'h0, 1'b0, base(c) + extra(c));
      type_b_pin <= 1'b0;
      repeat (4) @(posedge clk);
      $display("t_variant done");
   endtask
   task automatic t_waits;
      slow <= 1'b1;
      repeat (3) @(posedge clk);
      pair(5'h03, 32'h0, 1'b0, 8'h03 + {4'h0, RD});
      pair(5'h06, 32'h0, 1'b0, 8'h03 + {4'h0, RD});
      pair(5'h14, 32'h0070_0000, 1'b0, NS + 8'h01);
      pair(5'h15, 32'h0070_0000, 1'b0, NS + 8'h03);
      pair(5'h16, 32'h0070_0000, 1'b0, NS + 8'h01);
      pair(5'h17, 32'h0070_0000, 1'b0, NS + 8'h02);
      pair(5'h18, 32'h0070_0000, 1'b0, NS + 8'h02);
      pair(5'h19, 32'h0070_0000, 1'b1, NS + 8'h03);
      slow <= 1'b0;
      repeat (3) @(posedge clk);
      pair(5'h14, 32'h0, 1'b0, 8'h02);
      pair(5'h19, 32'h0, 1'b0, 8'h04);
      pair(5'h15, 32'hFFF0_0000, 1'b0, 8'h0F);
      $display("t_waits done");
   endtask
   task automatic t_fields;
      pair(5'h11, 32'h0000_381F, 1'b0, 8'h03);
      chk(32'(trap_vector), 32'h1F);
      chk(32'(bit_number), 32'h7);
      chk(32'(cond_code), 32'hF);
      pair(5'h11, 32'h0000_0000, 1'b0, 8'h03);
      chk(32'(trap_vector), 32'h00);
      $display("t_fields done");
   endtask
   task automatic t_reg3;
      @(posedge clk);
      res_valid <= 1'b1;
      res_is_div <= 1'b1;
      div_remainder <= 32'hA5A5_0001;
      product_high <= 32'h5A5A_0002;
      @(posedge clk);
      res_is_div <= 1'b0;
      @(posedge clk);
      res_valid <= 1'b0;
      chk(32'(reg3_we), 32'h1);
      chk(reg3_data, 32'hA5A5_0001);
      @(posedge clk);
      chk(reg3_data, 32'h5A5A_0002);
      @(posedge clk);
      chk(32'(reg3_we), 32'h0);
      $display("t_reg3 done");
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_basic();
      t_variant();
      t_waits();
      t_fields();
      t_reg3();
      conclude();
   end
   // whole run is under a thousand clocks
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      conclude();
   end
endmodule // cict_top_bench
`default_nettype wire
